// [common/odl_pkg.sv]
// Package for the output driver and signal-loss configuration registers
package odl_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] ADDR_DRIVER = 12'h001;
  localparam logic [11:0] ADDR_TOP = 12'h002;
  localparam logic [15:0] RST_DRIVER = 16'h0348;
  localparam logic [15:0] RST_TOP = 16'h0000;
  localparam logic [15:0] MASK_DRIVER = 16'h03ff;
  localparam logic [15:0] MASK_TOP = 16'h01fc;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int SWING1_BIT = 9;
  localparam int SWING0_BIT = 8;
  localparam int BOOST1_LSB = 5;
  localparam int BOOST0_LSB = 2;
  localparam int DEEN1_BIT = 1;
  localparam int DEEN0_BIT = 0;
  localparam int THR_LSB = 7;
  localparam int METH_LSB = 5;
  localparam int MUTE_BIT = 4;
  localparam int PWDN_BIT = 3;
  localparam int SDOZ_BIT = 2;
  // ****************************************
  // Detector methods and SPI framing
  // ****************************************
  localparam logic [1:0] METH_EDGE = 2'h0;
  localparam logic [1:0] METH_STRENGTH = 2'h1;
  localparam logic [1:0] METH_DUAL = 2'h2;
  localparam logic [5:0] CMD_BITS = 6'h10;
  localparam logic [5:0] FRAME_BITS = 6'h20;
  // ****************************************
  // Output settings carrier
  // ****************************************
  typedef struct packed {
    logic swing_low_second;
    logic swing_low_first;
    logic [2:0] boost_second;
    logic [2:0] boost_first;
    logic deemph_en_second;
    logic deemph_en_first;
  } odl_drv_s;
  typedef struct packed {
    logic [1:0] los_threshold;
    logic [1:0] los_method;
    logic los_mute_en;
    logic power_down;
    logic sdo_tristate_en;
  } odl_top_s;
endpackage : odl_pkg

// [sim/odl_regs_checker.sv]
// Checker for the configuration register block
`timescale 1ns/1ps
module odl_regs_checker (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic SCLK_EN_I,
  input wire logic CS_N_I,
  input wire logic SDO_OE_N_O,
  input wire logic LOS_EDGE_I,
  input wire logic LOS_STRENGTH_I,
  input wire logic SIGNAL_LOSS_FLAG_O,
  input wire logic OUTPUT_MUTE_O,
  input wire logic POWER_DOWN_O,
  input wire odl_pkg::odl_drv_s DRV_CFG_O,
  input wire logic [1:0] LOS_THRESHOLD_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_oe_driven: assert property (!CS_N_I |-> !SDO_OE_N_O) else $error("sdo floated");
  a_mute_cause: assert property (OUTPUT_MUTE_O |-> SIGNAL_LOSS_FLAG_O) else $error("bad mute");
  a_loss_both: assert property (LOS_EDGE_I && LOS_STRENGTH_I |=> SIGNAL_LOSS_FLAG_O) else $error("no loss");
  a_ok_both: assert property (!LOS_EDGE_I && !LOS_STRENGTH_I |=> !SIGNAL_LOSS_FLAG_O) else $error("bad loss");
  a_loss_hold: assert property ((LOS_EDGE_I && LOS_STRENGTH_I) [*2] |-> SIGNAL_LOSS_FLAG_O) else $error("loss dropped");
  a_drv_hold: assert property (!$past(SCLK_EN_I) |-> $stable(DRV_CFG_O)) else $error("driver moved");
  a_thr_hold: assert property (!$past(SCLK_EN_I) |-> $stable(LOS_THRESHOLD_O)) else $error("thr moved");
  a_pwdn_hold: assert property (!$past(SCLK_EN_I) |-> $stable(POWER_DOWN_O)) else $error("pwdn moved");
endmodule : odl_regs_checker
bind odl_regs odl_regs_checker u_odl_regs_checker (.*);

// [sim/odl_spi_host.sv]
// SPI host model that frames register accesses
`timescale 1ns/1ps
module odl_spi_host (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic sclk_en_o,
  output logic cs_n_o,
  output logic sdi_o
);
  initial begin
    sclk_en_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] dat, output logic [15:0] rd);
    logic [31:0] w;
    w = {cmd, dat};
    rd = 16'h0000;
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      sclk_en_o <= 1'b1;
      sdi_o <= w[i];
      @(posedge clk_i);
      sclk_en_o <= 1'b0;
      #1 if (i < 16) rd = {rd[14:0], sdo_i};
    end
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    @(posedge clk_i);
  endtask : xfer
endmodule : odl_spi_host

// [sim/tb_odl_regs.sv]
// Testbench for the configuration register block
`timescale 1ns/1ps
module tb_odl_regs;
  logic CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic LOS_EDGE_I = 1'b0;
  logic LOS_STRENGTH_I = 1'b0;
  logic SCLK_EN_I, CS_N_I, SDI_I, SDO_O, SDO_OE_N_O, SIGNAL_LOSS_FLAG_O, OUTPUT_MUTE_O, POWER_DOWN_O;
  odl_pkg::odl_drv_s DRV_CFG_O;
  logic [1:0] LOS_THRESHOLD_O;
  logic [15:0] rd;
  int fails = 0;
  int checks_done = 0;
  always #20 CLK_I = ~CLK_I;
  odl_regs u_odl_regs (.*);
  odl_spi_host u_odl_spi_host (.clk_i(CLK_I), .sdo_i(SDO_O), .sclk_en_o(SCLK_EN_I), .cs_n_o(CS_N_I), .sdi_o(SDI_I));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    u_odl_spi_host.xfer({4'h0, a}, d, rd);
  endtask : wr
  task automatic rg(input logic [11:0] a);
    u_odl_spi_host.xfer({4'h8, a}, 16'h0000, rd);
  endtask : rg
  task automatic t_driver;
    logic [15:0] v [3] = '{16'hffff, 16'hfd55, 16'h02aa};
    rg(12'h001);
    check(rd, 16'h0348);
    check({6'h0, DRV_CFG_O}, 16'h0348);
    foreach (v[i]) begin
      wr(12'h001, v[i]);
      check({6'h0, DRV_CFG_O}, v[i] & 16'h03ff);
      rg(12'h001);
      check(rd, v[i] & 16'h03ff);
    end
  endtask : t_driver
  task automatic t_top;
    logic exp;
    rg(12'h002);
    check(rd, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      wr(12'h002, {7'h7f, 2'(m), 2'(m), 5'h1b});
      rg(12'h002);
      check(rd, {7'h0, 2'(m), 2'(m), 5'h18});
      check({13'h0, LOS_THRESHOLD_O, POWER_DOWN_O}, {13'h0, 2'(m), 1'b1});
      for (int c = 0; c < 4; c++) begin
        @(posedge CLK_I);
        LOS_EDGE_I <= c[0];
        LOS_STRENGTH_I <= c[1];
        @(posedge CLK_I);
        #1 exp = (m == 1) ? c[1] : (m == 2) ? c[0] | c[1] : c[0];
        check({15'h0, SIGNAL_LOSS_FLAG_O}, {15'h0, exp});
        check({15'h0, OUTPUT_MUTE_O}, {15'h0, exp});
      end
    end
  endtask : t_top
  task automatic t_float;
    wr(12'h002, 16'h0004);
    check({14'h0, SDO_OE_N_O, OUTPUT_MUTE_O}, 16'h0002);
    wr(12'h002, 16'h0000);
    check({15'h0, SDO_OE_N_O}, 16'h0000);
    rg(12'h003);
    check(rd, 16'h0000);
  endtask : t_float
  task automatic t_reset;
    wr(12'h001, 16'h0000);
    wr(12'h002, 16'h0198);
    @(posedge CLK_I);
    RST_N_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    #1 check({6'h0, DRV_CFG_O}, 16'h0348);
    check({13'h0, LOS_THRESHOLD_O, POWER_DOWN_O}, 16'h0000);
    rg(12'h002);
    check(rd, 16'h0000);
    rg(12'h001);
    check(rd, 16'h0348);
  endtask : t_reset
  task automatic test_done;
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (12) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    t_driver;
    t_top;
    t_float;
    t_reset;
    test_done;
  end
  initial begin
    #200000;
    fails++;
    test_done;
  end
endmodule : tb_odl_regs

// [verilog/odl_regs.sv]
// Driver and signal-loss configuration registers behind the SPI host port
`timescale 1ns/1ps
// How it works
// - Bit 9 sets second output swing, reset 1
// - Bit 8 sets first output swing, reset 1
// - Bits 7:5 second output boost, reset 2
// - Bits 4:2 first output boost, reset 2
// - Bit 1 enables second output de-emphasis
// - Bit 0 enables first output de-emphasis
// - Top bits 8:7 set loss threshold
// - Top bits 6:5 pick loss detector
// - Top bit 4 mutes output on loss
// - Top bit 3 powers the chip down
// - Top bit 2 floats SDO when deselected
module odl_regs (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic SCLK_EN_I,
  input wire logic CS_N_I,
  input wire logic SDI_I,
  output logic SDO_O,
  output logic SDO_OE_N_O,
  input wire logic LOS_EDGE_I,
  input wire logic LOS_STRENGTH_I,
  output logic SIGNAL_LOSS_FLAG_O,
  output logic OUTPUT_MUTE_O,
  output logic POWER_DOWN_O,
  output odl_pkg::odl_drv_s DRV_CFG_O,
  output logic [1:0] LOS_THRESHOLD_O
);
  // ****************************************
  // SPI shifter: 16-bit command then 16-bit data
  // Command: bit15 read, bits 11:0 address
  // ****************************************
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [15:0] cmd_r;
  logic [15:0] cmd_nxt;
  logic [15:0] shin_r;
  logic [15:0] shin_nxt;
  logic [15:0] shout_r;
  logic [15:0] shout_nxt;
  logic [15:0] driver_r;
  logic [15:0] driver_nxt;
  logic [15:0] top_r;
  logic [15:0] top_nxt;
  logic [15:0] rdata;
  logic [15:0] wdata;
  logic sdo_r;
  logic sdo_nxt;
  logic los_r;
  logic los_nxt;
  logic bit_pulse;
  logic wr_last;
  odl_pkg::odl_top_s top_cfg;

  // ****************************************
  // Frame phase
  // ****************************************
  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_CMD = 4'b0010,
    PH_DATA = 4'b0100,
    PH_DONE = 4'b1000
  } odl_phase_e;

  odl_phase_e phase_r;
  odl_phase_e phase_nxt;

  // ****************************************
  // Shared decoders
  // ****************************************
  function automatic logic addr_hit(input logic [15:0] cmd, input logic [11:0] addr);
    addr_hit = (cmd[11:0] == addr);
  endfunction : addr_hit

  function automatic logic is_write(input logic [15:0] cmd);
    is_write = !cmd[15];
  endfunction : is_write

  function automatic logic at_bit(input logic [5:0] cnt, input logic [5:0] pos);
    at_bit = (cnt == pos);
  endfunction : at_bit

  function automatic logic los_pick(input logic [1:0] method, input logic edge_loss, input logic level_loss);
    los_pick = edge_loss;
    case (method)
      odl_pkg::METH_EDGE: los_pick = edge_loss;
      odl_pkg::METH_STRENGTH: los_pick = level_loss;
      odl_pkg::METH_DUAL: los_pick = edge_loss || level_loss;
      default: los_pick = edge_loss;
    endcase
  endfunction : los_pick

  assign bit_pulse = !CS_N_I && SCLK_EN_I;

  // ****************************************
  // Phase machine, deselect always returns idle
  // ****************************************
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      PH_IDLE: begin
        if (!CS_N_I) begin
          phase_nxt = PH_CMD;
        end
      end
      PH_CMD: begin
        if (CS_N_I) begin
          phase_nxt = PH_IDLE;
        end else if (SCLK_EN_I && at_bit(cnt_r, odl_pkg::CMD_BITS - 6'h01)) begin
          phase_nxt = PH_DATA;
        end
      end
      PH_DATA: begin
        if (CS_N_I) begin
          phase_nxt = PH_IDLE;
        end else if (SCLK_EN_I && at_bit(cnt_r, odl_pkg::FRAME_BITS - 6'h01)) begin
          phase_nxt = PH_DONE;
        end
      end
      PH_DONE: begin
        if (CS_N_I) begin
          phase_nxt = PH_IDLE;
        end
      end
      default: begin
        phase_nxt = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      phase_r <= PH_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ****************************************
  // Bit counter, cleared while deselected
  // ****************************************
  always_comb begin
    cnt_nxt = cnt_r;
    if (CS_N_I) begin
      cnt_nxt = 6'h00;
    end else if (SCLK_EN_I && !at_bit(cnt_r, odl_pkg::FRAME_BITS)) begin
      cnt_nxt = cnt_r + 6'h01;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************
  // Serial input and command capture
  // ****************************************
  always_comb begin
    shin_nxt = shin_r;
    cmd_nxt = cmd_r;
    if (bit_pulse) begin
      shin_nxt = {shin_r[14:0], SDI_I};
      if (at_bit(cnt_r, odl_pkg::CMD_BITS - 6'h01)) begin
        cmd_nxt = {shin_r[14:0], SDI_I};
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      shin_r <= 16'h0000;
    end else begin
      shin_r <= shin_nxt;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cmd_r <= 16'h0000;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  // ****************************************
  // Read data and serial output
  // ****************************************
  always_comb begin
    rdata = 16'h0000;
    if (addr_hit(cmd_r, odl_pkg::ADDR_DRIVER)) begin
      rdata = driver_r;
    end else if (addr_hit(cmd_r, odl_pkg::ADDR_TOP)) begin
      rdata = top_r;
    end
  end

  always_comb begin
    shout_nxt = shout_r;
    sdo_nxt = sdo_r;
    if (bit_pulse) begin
      if (at_bit(cnt_r, odl_pkg::CMD_BITS)) begin
        shout_nxt = {rdata[14:0], 1'b0};
        sdo_nxt = rdata[15];
      end else begin
        shout_nxt = {shout_r[14:0], 1'b0};
        sdo_nxt = shout_r[15];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      shout_r <= 16'h0000;
    end else begin
      shout_r <= shout_nxt;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sdo_r <= 1'b0;
    end else begin
      sdo_r <= sdo_nxt;
    end
  end

  // ****************************************
  // Register writes at the last data bit
  // ****************************************
  assign wdata = {shin_r[14:0], SDI_I};
  assign wr_last = bit_pulse && phase_r == PH_DATA
    && at_bit(cnt_r, odl_pkg::FRAME_BITS - 6'h01) && is_write(cmd_r);

  always_comb begin
    driver_nxt = driver_r;
    if (wr_last && addr_hit(cmd_r, odl_pkg::ADDR_DRIVER)) begin
      driver_nxt = wdata & odl_pkg::MASK_DRIVER;
    end
  end

  always_comb begin
    top_nxt = top_r;
    if (wr_last && addr_hit(cmd_r, odl_pkg::ADDR_TOP)) begin
      top_nxt = wdata & odl_pkg::MASK_TOP;
    end
  end

  // ****************************************
  // Register state
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      driver_r <= odl_pkg::RST_DRIVER;
    end else begin
      driver_r <= driver_nxt;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      top_r <= odl_pkg::RST_TOP;
    end else begin
      top_r <= top_nxt;
    end
  end

  // ****************************************
  // Field outputs
  // ****************************************
  assign top_cfg = top_r[odl_pkg::THR_LSB + 1:odl_pkg::SDOZ_BIT];
  assign DRV_CFG_O.swing_low_second = driver_r[odl_pkg::SWING1_BIT];
  assign DRV_CFG_O.swing_low_first = driver_r[odl_pkg::SWING0_BIT];
  assign DRV_CFG_O.boost_second = driver_r[odl_pkg::BOOST1_LSB +: 3];
  assign DRV_CFG_O.boost_first = driver_r[odl_pkg::BOOST0_LSB +: 3];
  assign DRV_CFG_O.deemph_en_second = driver_r[odl_pkg::DEEN1_BIT];
  assign DRV_CFG_O.deemph_en_first = driver_r[odl_pkg::DEEN0_BIT];
  assign LOS_THRESHOLD_O = top_cfg.los_threshold;
  assign POWER_DOWN_O = top_cfg.power_down;

  // ****************************************
  // Signal-loss selection and mute
  // ****************************************
  assign los_nxt = los_pick(top_cfg.los_method, LOS_EDGE_I, LOS_STRENGTH_I);

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      los_r <= 1'b0;
    end else begin
      los_r <= los_nxt;
    end
  end

  assign SIGNAL_LOSS_FLAG_O = los_r;
  assign OUTPUT_MUTE_O = los_r && top_cfg.los_mute_en;
  assign SDO_O = sdo_r;
  assign SDO_OE_N_O = CS_N_I && top_cfg.sdo_tristate_en;
endmodule : odl_regs
